// File: tb/pclc_sva.sv
// assertion checker for the pwm cycle block
`timescale 1ns/10ps
`default_nettype none
module pclc_sva (
    input wire logic I_CORE_CLK, I_ARST_N, I_SFR_WR, I_SFR_RD, I_COUNT_TICK,
    input wire logic [7:0] I_SFR_ADDR, I_SFR_WDATA, O_SFR_RDATA,
    input wire logic [15:0] I_MAIN_COUNTER,
    input wire logic [5:0] I_CH_PWM_EN, I_CH_WIDE_PWM_SEL, O_CH_NARROW_PWM,
    input wire logic [95:0] O_CH_COMPARE,
    input wire logic [1:0] O_CYCLE_LEN_SEL,
    input wire logic O_CYCLE_OVF, O_IRQ_REQ
);
    // ****
    // properties
    // ****
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_ARST_N);
    logic hit, cfg_wr;
    assign cfg_wr = I_SFR_WR && I_SFR_ADDR == pclc_pkg::CFG_ADDR;
    assign hit = I_COUNT_TICK && &(I_MAIN_COUNTER | ~((16'h0100 << O_CYCLE_LEN_SEL) - 16'h0001));
    sequence s_cfg_rd;
        I_SFR_RD && I_SFR_ADDR == pclc_pkg::CFG_ADDR;
    endsequence
    sequence s_cfg_wr;
        cfg_wr;
    endsequence
    AST_OVF_SET: assert property (hit |=> O_CYCLE_OVF)
        else $error("overflow pulse missing");
    AST_OVF_CAUSE: assert property (O_CYCLE_OVF |-> $past(hit))
        else $error("overflow pulse without cause");
    AST_IRQ_HOLD: assert property (O_IRQ_REQ && !cfg_wr |=> O_IRQ_REQ)
        else $error("request dropped without clear");
    AST_IRQ_RISE: assert property ($rose(O_IRQ_REQ) |-> $past(cfg_wr) || O_CYCLE_OVF)
        else $error("request raised without cause");
    AST_RSVD_ZERO: assert property (s_cfg_rd |=> O_SFR_RDATA[4:2] == 3'h0)
        else $error("unused bits read nonzero");
    AST_LEN_WR: assert property (
        s_cfg_wr |=> {6'h00, O_CYCLE_LEN_SEL} == ($past(I_SFR_WDATA) & 8'h03))
        else $error("cycle length not taken");
    AST_CMP_HOLD: assert property (
        !$past(I_SFR_WR) && (!O_CYCLE_OVF || $past(O_CYCLE_LEN_SEL) == 2'h0)
        |-> $stable(O_CH_COMPARE))
        else $error("compare changed without cause");
    AST_NARROW: assert property (O_CH_NARROW_PWM == (I_CH_PWM_EN & ~I_CH_WIDE_PWM_SEL))
        else $error("narrow pwm select wrong");
endmodule : pclc_sva
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the pwm cycle block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ****
    // stimulus and checks
    // ****
    logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, tk = 1'h0, ovf, irq;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
    logic [15:0] cnt = 16'h0000;
    logic [5:0] pen = 6'h01, wsel = 6'h02, npwm;
    logic [95:0] cmp;
    logic [1:0] len;
    int mismatches = 0, compares = 0;
    logic [7:0] rows [5][2] = '{'{8'h03, 8'h03}, '{8'h1e, 8'h02}, '{8'h81, 8'h81},
        '{8'h42, 8'h42}, '{8'h00, 8'h00}};
    pclc_pwm_cycle i_dut (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_SFR_ADDR(addr),
        .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wd), .O_SFR_RDATA(rdat),
        .I_MAIN_COUNTER(cnt), .I_COUNT_TICK(tk), .I_CH_PWM_EN(pen),
        .I_CH_WIDE_PWM_SEL(wsel), .O_CH_COMPARE(cmp), .O_CH_NARROW_PWM(npwm),
        .O_CYCLE_LEN_SEL(len), .O_CYCLE_OVF(ovf), .O_IRQ_REQ(irq));
    task automatic chk(input logic [15:0] s, e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("Error %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wrt(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        #1;
    endtask : wrt
    task automatic rdc(input logic [7:0] a, e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 chk({8'h00, rdat}, {8'h00, e});
    endtask : rdc
    task automatic tick(input logic [15:0] c, input logic [1:0] e);
        @(posedge clk);
        cnt <= c;
        tk <= 1'h1;
        @(posedge clk);
        tk <= 1'h0;
        #1 chk({14'h0000, ovf, irq}, {14'h0000, e});
    endtask : tick
    task automatic final_report;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        #50000;
        mismatches++;
        final_report;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        for (int i = 0; i < 5; i++) begin
            wrt(pclc_pkg::CFG_ADDR, rows[i][0]);
            rdc(pclc_pkg::CFG_ADDR, rows[i][1]);
            chk({14'h0000, len}, {14'h0000, rows[i][1][1:0]});
        end
        for (int l = 0; l < 4; l++) begin
            wrt(pclc_pkg::CFG_ADDR, {1'h0, l[0], 4'h0, l[1:0]});
            tick((16'h0100 << l) - 16'h0002, 2'h0);
            tick((16'h0100 << l) - 16'h0001, {1'h1, l[0]});
            tick(16'h0000, {1'h0, l[0]});
            rdc(pclc_pkg::CFG_ADDR, {1'h0, l[0], 4'h8, l[1:0]});
            wrt(pclc_pkg::CFG_ADDR, {6'h00, l[1:0]});
            rdc(pclc_pkg::CFG_ADDR, {6'h00, l[1:0]});
        end
        wrt(pclc_pkg::CFG_ADDR, 8'h20);
        chk({15'h0000, irq}, 16'h0000);
        wrt(pclc_pkg::CFG_ADDR, 8'h60);
        chk({15'h0000, irq}, 16'h0001);
        wrt(8'he9, 8'h11);
        wrt(8'hf1, 8'h22);
        wrt(pclc_pkg::CFG_ADDR, 8'h81);
        wrt(8'he9, 8'h33);
        wrt(8'hf1, 8'h44);
        wrt(8'hea, 8'h77);
        rdc(8'he9, 8'h33);
        chk(cmp[15:0], 16'h2211);
        tick(16'h01ff, 2'h2);
        chk(cmp[15:0], 16'h4433);
        chk(cmp[31:16], 16'h0000);
        wrt(8'he9, 8'h55);
        wrt(pclc_pkg::CFG_ADDR, 8'h80);
        tick(16'h00ff, 2'h2);
        chk(cmp[15:0], 16'h4433);
        @(posedge clk);
        addr <= pclc_pkg::CFG_ADDR;
        wd <= 8'h40;
        wr <= 1'h1;
        cnt <= 16'h00ff;
        tk <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
        tk <= 1'h0;
        #1 chk({15'h0000, irq}, 16'h0001);
        rdc(8'h00, 8'h00);
        rst_n <= 1'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        rdc(pclc_pkg::CFG_ADDR, 8'h00);
        final_report;
    end
endmodule : tb_top
bind pclc_pwm_cycle pclc_sva i_sva (.*);
`default_nettype wire

// File: verilog/pclc_pkg.sv
// constants for the pwm cycle length configuration block
package pclc_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] CFG_ADDR = 8'hd9;
    localparam logic [7:0] CMP_LOW_BASE = 8'he9;
    localparam logic [7:0] CMP_HIGH_BASE = 8'hf1;
    localparam int NUM_CH = 6;

    // ****************************************
    // configuration register fields
    // ****************************************
    localparam int BANK_SEL_BIT = 7;
    localparam int OVF_IE_BIT = 6;
    localparam int OVF_FLAG_BIT = 5;
    localparam int LEN_SEL_LSB = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET = 16'h0000;

    // ****************************************
    // cycle length encodings
    // ****************************************
    typedef enum logic [1:0] {
        LEN_8 = 2'h0,
        LEN_9 = 2'h1,
        LEN_10 = 2'h2,
        LEN_11 = 2'h3
    } pclc_len_t;

endpackage : pclc_pkg

// File: verilog/pclc_pwm_cycle.sv
// pwm cycle length configuration, overflow flag and compare/reload steering
// ****************************************
// Overview of operation
// - the reload bank select bit steers compare byte accesses to compare (0) or reload (1) storage.
// - reload values only act in the 9, 10 and 11-bit pwm modes and are merely held otherwise.
// - the interrupt request is raised while the overflow flag is set and its enable bit is 1.
// - the overflow flag is set when the main counter overflows out of the selected bit 8 to 11.
// - the overflow flag is set by hardware or a software 1 and cleared only by a software 0.
// - register bits 4 to 2 read as zero and ignore writes.
// - cycle length select 00/01/10/11 gives 8/9/10/11-bit cycles.
// - the cycle length applies to all narrow pwm channels and not to 16-bit channels.
// - a channel's wide pwm select picks 16-bit pwm only while its pwm mode is enabled.
// ****************************************
`timescale 1ns/10ps
`default_nettype none

module pclc_pwm_cycle (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_ARST_N,
    // special function register port
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic I_SFR_WR,
    input wire logic I_SFR_RD,
    input wire logic [7:0] I_SFR_WDATA,
    output logic [7:0] O_SFR_RDATA,
    // main counter and channel modes
    input wire logic [15:0] I_MAIN_COUNTER,
    input wire logic I_COUNT_TICK,
    input wire logic [5:0] I_CH_PWM_EN,
    input wire logic [5:0] I_CH_WIDE_PWM_SEL,
    // channel results
    output logic [95:0] O_CH_COMPARE,
    output logic [5:0] O_CH_NARROW_PWM,
    output logic [1:0] O_CYCLE_LEN_SEL,
    output logic O_CYCLE_OVF,
    output logic O_IRQ_REQ
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic bank_sel;
        logic ovf_ie;
        logic ovf_flag;
        logic [1:0] len_sel;
        logic [5:0][15:0] cmp;
        logic [5:0][15:0] reload;
        logic [7:0] rdata;
        logic ovf_pulse;
    } pclc_state_t;

    pclc_state_t st_reg;
    pclc_state_t st_next;

    // ****************************************
    // helpers
    // ****************************************
    // overflow out of the selected bit: low bits all ones on a tick
    function automatic logic ovf_at(input logic [1:0] sel, input logic [15:0] cnt);
        logic r;
        r = 1'b0;
        case (sel)
            pclc_pkg::LEN_8: r = &cnt[7:0];
            pclc_pkg::LEN_9: r = &cnt[8:0];
            pclc_pkg::LEN_10: r = &cnt[9:0];
            pclc_pkg::LEN_11: r = &cnt[10:0];
            default: r = 1'b0;
        endcase
        return r;
    endfunction : ovf_at

    // channel slot of a compare byte address, valid flag in bit 3
    function automatic logic [3:0] slot_of(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] d;
        d = addr - base;
        if (d < 8'(pclc_pkg::NUM_CH)) begin
            return {1'b1, d[2:0]};
        end
        return 4'h0;
    endfunction : slot_of

    // config register image, unused bits read as zero
    function automatic logic [7:0] cfg_image(input pclc_state_t s);
        logic [7:0] v;
        v = 8'h00;
        v[pclc_pkg::BANK_SEL_BIT] = s.bank_sel;
        v[pclc_pkg::OVF_IE_BIT] = s.ovf_ie;
        v[pclc_pkg::OVF_FLAG_BIT] = s.ovf_flag;
        v[pclc_pkg::LEN_SEL_LSB +: 2] = s.len_sel;
        return v;
    endfunction : cfg_image

    // byte of the bank chosen by the select bit
    function automatic logic [7:0] bank_byte(input pclc_state_t s, input logic [2:0] ch,
                                             input logic hi);
        logic [15:0] w;
        w = s.bank_sel ? s.reload[ch] : s.cmp[ch];
        return hi ? w[15:8] : w[7:0];
    endfunction : bank_byte

    // one byte replaced in a compare or reload word
    function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = w;
        if (hi) begin
            r[15:8] = b;
        end else begin
            r[7:0] = b;
        end
        return r;
    endfunction : put_byte

    // ****************************************
    // decode
    // ****************************************
    logic hw_ovf;
    logic cfg_hit;
    logic [3:0] lo_slot;
    logic [3:0] hi_slot;
    logic [5:0] narrow;

    always_comb begin
        hw_ovf = I_COUNT_TICK & ovf_at(st_reg.len_sel, I_MAIN_COUNTER);
        cfg_hit = I_SFR_ADDR == pclc_pkg::CFG_ADDR;
        lo_slot = slot_of(I_SFR_ADDR, pclc_pkg::CMP_LOW_BASE);
        hi_slot = slot_of(I_SFR_ADDR, pclc_pkg::CMP_HIGH_BASE);
        narrow = I_CH_PWM_EN & ~I_CH_WIDE_PWM_SEL;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.ovf_pulse = hw_ovf;
        // configuration register write
        if (I_SFR_WR && cfg_hit) begin
            st_next.bank_sel = I_SFR_WDATA[pclc_pkg::BANK_SEL_BIT];
            st_next.ovf_ie = I_SFR_WDATA[pclc_pkg::OVF_IE_BIT];
            st_next.ovf_flag = I_SFR_WDATA[pclc_pkg::OVF_FLAG_BIT];
            st_next.len_sel = I_SFR_WDATA[pclc_pkg::LEN_SEL_LSB +: 2];
        end
        // cycle boundary reload, narrow 9 to 11-bit channels only
        if (hw_ovf && st_reg.len_sel != pclc_pkg::LEN_8) begin
            for (int i = 0; i < pclc_pkg::NUM_CH; i++) begin
                if (narrow[i]) begin
                    st_next.cmp[i] = st_reg.reload[i];
                end
            end
        end
        // compare byte writes steered by bank select
        if (I_SFR_WR && lo_slot[3]) begin
            if (st_reg.bank_sel) begin
                st_next.reload[lo_slot[2:0]] = put_byte(st_next.reload[lo_slot[2:0]],
                                                        1'b0, I_SFR_WDATA);
            end else begin
                st_next.cmp[lo_slot[2:0]] = put_byte(st_next.cmp[lo_slot[2:0]],
                                                     1'b0, I_SFR_WDATA);
            end
        end
        if (I_SFR_WR && hi_slot[3]) begin
            if (st_reg.bank_sel) begin
                st_next.reload[hi_slot[2:0]] = put_byte(st_next.reload[hi_slot[2:0]],
                                                        1'b1, I_SFR_WDATA);
            end else begin
                st_next.cmp[hi_slot[2:0]] = put_byte(st_next.cmp[hi_slot[2:0]],
                                                     1'b1, I_SFR_WDATA);
            end
        end
        // hardware set wins over a software clear
        if (hw_ovf) begin
            st_next.ovf_flag = 1'b1;
        end
        // read data, unmapped addresses read zero
        if (I_SFR_RD) begin
            st_next.rdata = 8'h00;
            if (cfg_hit) begin
                st_next.rdata = cfg_image(st_reg);
            end else if (lo_slot[3]) begin
                st_next.rdata = bank_byte(st_reg, lo_slot[2:0], 1'b0);
            end else if (hi_slot[3]) begin
                st_next.rdata = bank_byte(st_reg, hi_slot[2:0], 1'b1);
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_reg.bank_sel <= pclc_pkg::CFG_RESET[pclc_pkg::BANK_SEL_BIT];
            st_reg.ovf_ie <= pclc_pkg::CFG_RESET[pclc_pkg::OVF_IE_BIT];
            st_reg.ovf_flag <= pclc_pkg::CFG_RESET[pclc_pkg::OVF_FLAG_BIT];
            st_reg.len_sel <= pclc_pkg::CFG_RESET[pclc_pkg::LEN_SEL_LSB +: 2];
            st_reg.cmp <= {pclc_pkg::NUM_CH{pclc_pkg::CMP_RESET}};
            st_reg.reload <= {pclc_pkg::NUM_CH{pclc_pkg::CMP_RESET}};
            st_reg.rdata <= 8'h00;
            st_reg.ovf_pulse <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // register port outputs
    // ****************************************
    assign O_SFR_RDATA = st_reg.rdata;

    // ****************************************
    // channel and interrupt outputs
    // ****************************************
    assign O_CH_COMPARE = st_reg.cmp;
    assign O_CH_NARROW_PWM = narrow;
    assign O_CYCLE_LEN_SEL = st_reg.len_sel;
    assign O_CYCLE_OVF = st_reg.ovf_pulse;
    assign O_IRQ_REQ = st_reg.ovf_flag & st_reg.ovf_ie;

endmodule : pclc_pwm_cycle

`default_nettype wire
